/* common/adc_ctrl_pkg.sv */
// Package of constants and carrier types for the converter host controller
// Function
// - Input select is latched when conversion-active falls; host settles it beforehand.
// - Host keeps standby request high normally; low puts the device in standby.
// - Host without gated reads may tie chip select and read low, enable high.
// - Board straps configuration pin to control ground and test pin to supply.
`default_nettype none
package adc_ctrl_pkg;
    localparam int RESULT_W       = 12;
    localparam int CLK_HZ         = 50_000_000;
    localparam int MAX_RATE_HZ    = 1_500_000;
    // Least start spacing, rounded up to whole cycles
    localparam int START_GAP_CYC  = (CLK_HZ + MAX_RATE_HZ - 1) / MAX_RATE_HZ;
    localparam int SH_LOW_NS      = 60;
    localparam int CLK_NS         = 20;
    localparam int SH_LOW_CYC     = (SH_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_HOLD_NS     = 60;
    localparam int RD_HOLD_CYC    = (RD_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W          = 8;
    localparam int FIFO_DEPTH     = 2;

    typedef struct packed {
        logic chip_select_n;
        logic sample_hold;
        logic read_n;
        logic output_enable;
        logic input_select;
        logic standby_request_n;
    } pin_ctrl_t;

    typedef struct packed {
        logic                channel;
        logic [RESULT_W-1:0] data;
    } sample_t;
endpackage : adc_ctrl_pkg
`default_nettype wire

/* core/chan_mem.sv */
// Small memory remembering the channel tag of each conversion in flight
`default_nettype none
module chan_mem
    import adc_ctrl_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic ref_clk_in,
    input  wire logic reset_in,
    input  wire logic wr_en_in,
    input  wire logic wr_data_in,
    input  wire logic rd_en_in,
    output var  logic rd_data_out,
    output var  logic empty_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [DEPTH-1:0] mem_reg, mem_next;
    logic [AW:0]      wp_reg, wp_next, rp_reg, rp_next;
    logic             rd_reg, rd_next;

    always_comb begin
        mem_next = mem_reg;
        wp_next  = wp_reg;
        rp_next  = rp_reg;
        rd_next  = rd_reg;
        // Overwrite on overflow; the controller never has more than DEPTH in flight
        if (wr_en_in) begin
            mem_next[wp_reg[AW-1:0]] = wr_data_in;
            wp_next = wp_reg + 1'b1;
        end
        if (rd_en_in && (wp_reg != rp_reg)) begin
            rd_next = mem_reg[rp_reg[AW-1:0]];
            rp_next = rp_reg + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            mem_reg <= '0;
            wp_reg  <= '0;
            rp_reg  <= '0;
            rd_reg  <= 1'b0;
        end else begin
            mem_reg <= mem_next;
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            rd_reg  <= rd_next;
        end
    end

    assign rd_data_out = rd_reg;
    assign empty_out   = (wp_reg == rp_reg);
endmodule : chan_mem
`default_nettype wire

/* core/adc_host_ctrl.sv */
// Host controller driving the converter's pins and collecting results
`default_nettype none
module adc_host_ctrl
    import adc_ctrl_pkg::*;
#(
    parameter int GAP_CYC  = START_GAP_CYC,
    parameter int LOW_CYC  = SH_LOW_CYC,
    parameter int HOLD_CYC = RD_HOLD_CYC
) (
    input  wire logic                ref_clk_in,
    input  wire logic                reset_in,
    // User side
    input  wire logic                start_in,
    input  wire logic                channel_in,
    input  wire logic                standby_in,
    output var  logic                busy_out,
    output var  logic                result_valid_out,
    output var  logic [RESULT_W-1:0] result_data_out,
    output var  logic                result_channel_out,
    // Device pins
    output var  logic                chip_select_n_out,
    output var  logic                sample_hold_out,
    output var  logic                read_n_out,
    output var  logic                output_enable_out,
    output var  logic                input_select_out,
    output var  logic                standby_request_n_out,
    input  wire logic                conv_active_in,
    input  wire logic                done_irq_n_in,
    input  wire logic [RESULT_W-1:0] result_bus_in
);
    typedef enum logic [2:0] {IDLE, SETUP, SH_LOW, WAIT_DONE, READ, RECOVER} state_t;

    state_t              state_reg, state_next;
    pin_ctrl_t           pins_reg, pins_next;
    logic [CNT_W-1:0]    cnt_reg, cnt_next;
    logic [CNT_W-1:0]    gap_reg, gap_next;
    logic                valid_reg, valid_next;
    logic [RESULT_W-1:0] data_reg, data_next;
    logic                chan_reg, chan_next;
    logic                tag_wr, tag_rd, tag_q, tag_empty;
    logic                start_ok;
    logic                cnt_zero;
    logic                irq_seen;
    logic                busy_reg, busy_next;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        return CNT_W'(n);
    endfunction : cyc

    chan_mem #(.DEPTH(FIFO_DEPTH)) u_chan_mem (
        .ref_clk_in (ref_clk_in),
        .reset_in   (reset_in),
        .wr_en_in   (tag_wr),
        .wr_data_in (pins_reg.input_select),
        .rd_en_in   (tag_rd),
        .rd_data_out(tag_q),
        .empty_out  (tag_empty)
    );

    // Conversion-active high means the device can take another start
    assign start_ok = start_in && !standby_in && conv_active_in && (gap_reg == '0);
    assign cnt_zero = (cnt_reg == '0);
    assign irq_seen = !done_irq_n_in;

    // Sequencer
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            IDLE: begin
                if (start_ok) begin
                    state_next = SETUP;
                end
            end
            SETUP: begin
                state_next = SH_LOW;
            end
            SH_LOW: begin
                if (cnt_zero) begin
                    state_next = WAIT_DONE;
                end
            end
            WAIT_DONE: begin
                // No timeout: a device that never interrupts keeps the controller here
                if (irq_seen) begin
                    state_next = READ;
                end
            end
            READ: begin
                if (cnt_zero) begin
                    state_next = RECOVER;
                end
            end
            RECOVER: begin
                state_next = IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            state_reg <= IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Pin drive; chip select stays low across the whole transfer
    // Mode and test straps are board wiring and never driven here
    always_comb begin
        pins_next = pins_reg;
        pins_next.standby_request_n = ~standby_in;
        unique case (state_reg)
            IDLE: begin
                if (start_ok) begin
                    pins_next.input_select  = channel_in;
                    pins_next.chip_select_n = 1'b0;
                end
            end
            SETUP: begin
                pins_next.sample_hold = 1'b0;
            end
            SH_LOW: begin
                if (cnt_zero) begin
                    pins_next.sample_hold = 1'b1;
                end
            end
            WAIT_DONE: begin
                // Select held past the conversion-active fall so it is latched cleanly
                // Gated reads rather than tied pins, so the bus is free between results
                if (irq_seen) begin
                    pins_next.read_n        = 1'b0;
                    pins_next.output_enable = 1'b1;
                end
            end
            READ: begin
                if (cnt_zero) begin
                    pins_next.read_n        = 1'b1;
                    pins_next.output_enable = 1'b0;
                    pins_next.chip_select_n = 1'b1;
                end
            end
            RECOVER: begin
                pins_next.chip_select_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            pins_reg <= '{chip_select_n: 1'b1, sample_hold: 1'b1, read_n: 1'b1,
                          output_enable: 1'b0, input_select: 1'b0, standby_request_n: 1'b1};
        end else begin
            pins_reg <= pins_next;
        end
    end

    // Phase and start-gap counters only count down, so a stale load cannot stretch a phase
    always_comb begin
        cnt_next = cnt_zero ? cnt_reg : cnt_reg - 1'b1;
        gap_next = (gap_reg != '0) ? gap_reg - 1'b1 : gap_reg;
        if (state_reg == SETUP) begin
            cnt_next = cyc(LOW_CYC);
            gap_next = cyc(GAP_CYC);
        end
        if ((state_reg == WAIT_DONE) && irq_seen) begin
            cnt_next = cyc(HOLD_CYC);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            cnt_reg <= '0;
            gap_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
            gap_reg <= gap_next;
        end
    end

    // Channel tags pair with results in start order
    assign tag_wr = (state_reg == SETUP);
    assign tag_rd = (state_reg == READ) && cnt_zero && !tag_empty;

    // Result capture while the bus is still driven
    always_comb begin
        valid_next = 1'b0;
        data_next  = data_reg;
        chan_next  = chan_reg;
        if ((state_reg == READ) && cnt_zero) begin
            data_next = result_bus_in;
        end
        if (state_reg == RECOVER) begin
            valid_next = 1'b1;
            chan_next  = tag_q;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            valid_reg <= 1'b0;
            data_reg  <= '0;
            chan_reg  <= 1'b0;
        end else begin
            valid_reg <= valid_next;
            data_reg  <= data_next;
            chan_reg  <= chan_next;
        end
    end

    // Busy looks one state ahead so it rises with chip select
    always_comb begin
        busy_next = (state_next != IDLE);
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= busy_next;
        end
    end

    assign busy_out              = busy_reg;
    assign result_valid_out      = valid_reg;
    assign result_data_out       = data_reg;
    assign result_channel_out    = chan_reg;
    assign chip_select_n_out     = pins_reg.chip_select_n;
    assign sample_hold_out       = pins_reg.sample_hold;
    assign read_n_out            = pins_reg.read_n;
    assign output_enable_out     = pins_reg.output_enable;
    assign input_select_out      = pins_reg.input_select;
    assign standby_request_n_out = pins_reg.standby_request_n;
endmodule : adc_host_ctrl
`default_nettype wire

/* sim/adc_host_ctrl_checker.sv */
// Pin timing checks for the converter host controller
`default_nettype none
module adc_host_ctrl_checker #(
    parameter int GAP_CYC = 34
) (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic standby_in,
    input wire logic result_valid_out,
    input wire logic chip_select_n_out,
    input wire logic sample_hold_out,
    input wire logic read_n_out,
    input wire logic output_enable_out,
    input wire logic input_select_out,
    input wire logic standby_request_n_out,
    input wire logic conv_active_in,
    input wire logic done_irq_n_in
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    logic [7:0] since_reg;
    // Saturates so a long idle spell never wraps into a false gap
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) since_reg <= 8'hff;
        else if ($fell(sample_hold_out)) since_reg <= 8'h00;
        else if (since_reg != 8'hff) since_reg <= since_reg + 8'h01;
    end
    sequence s_sh_pulse; !sample_hold_out [*4] ##1 sample_hold_out; endsequence
    sequence s_read_done; ##[3:5] $rose(read_n_out) ##[0:1] result_valid_out; endsequence
    property p_sh_width; $fell(sample_hold_out) |-> s_sh_pulse; endproperty
    property p_sh_cs; $fell(sample_hold_out) |-> !chip_select_n_out; endproperty
    property p_sh_ok; $fell(sample_hold_out) |-> standby_request_n_out && conv_active_in
        && since_reg >= GAP_CYC - 1; endproperty
    property p_rd_cs; !read_n_out |-> !chip_select_n_out; endproperty
    property p_oe_rd; output_enable_out |-> !read_n_out && !chip_select_n_out; endproperty
    property p_sel; $fell(conv_active_in) |-> $stable(input_select_out) && !chip_select_n_out; endproperty
    // Interrupt may arrive during the strobe; answer is due once the strobe is back high
    property p_irq_read; !done_irq_n_in && sample_hold_out && !chip_select_n_out && read_n_out
        |-> ##1 (!read_n_out && output_enable_out); endproperty
    property p_read; $fell(read_n_out) |-> s_read_done; endproperty
    property p_valid; result_valid_out |=> !result_valid_out; endproperty
    property p_standby; 1'b1 |=> standby_request_n_out == !$past(standby_in); endproperty
    a_sh_width: assert property (p_sh_width) else $error("sample hold low time wrong");
    a_sh_cs: assert property (p_sh_cs) else $error("start without chip select");
    a_sh_ok: assert property (p_sh_ok) else $error("start not allowed now");
    a_rd_cs: assert property (p_rd_cs) else $error("read without chip select");
    a_oe_rd: assert property (p_oe_rd) else $error("output enable outside read");
    a_sel: assert property (p_sel) else $error("select moved at latch");
    a_irq_read: assert property (p_irq_read) else $error("interrupt not answered");
    a_read: assert property (p_read) else $error("read length or result late");
    a_valid: assert property (p_valid) else $error("result pulse too long");
    a_standby: assert property (p_standby) else $error("standby pin wrong");
endmodule : adc_host_ctrl_checker
bind adc_host_ctrl adc_host_ctrl_checker #(.GAP_CYC(GAP_CYC)) adc_host_ctrl_checker_i (.*);
`default_nettype wire

/* sim/adc_dev_model.sv */
// Behavioural model of the converter's digital pins
`default_nettype none
module adc_dev_model (
    input  wire logic        ref_clk_in,
    input  wire logic        reset_in,
    input  wire logic [7:0]  conv_cyc_in,
    input  wire logic        chip_select_n_in,
    input  wire logic        sample_hold_in,
    input  wire logic        read_n_in,
    input  wire logic        output_enable_in,
    input  wire logic        input_select_in,
    input  wire logic        standby_request_n_in,
    output logic             conv_active_out,
    output logic             done_irq_n_out,
    output logic [11:0]      result_bus_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  cnt_reg, n_reg;
    logic        sh_reg, sel_reg;
    logic [11:0] lat_reg, last_reg;
    logic        drive;
    assign drive = output_enable_in && !chip_select_n_in && !read_n_in;
    // No pull on the bus: a floated bus shows the inverse, never stale data
    assign result_bus_out = drive ? lat_reg : ~last_reg;
    always_ff @(posedge ref_clk_in) begin
        sh_reg <= sample_hold_in;
        if (drive) last_reg <= lat_reg;
        if (reset_in) begin
            conv_active_out <= 1'b1;
            done_irq_n_out <= 1'b1;
            cnt_reg <= 8'h00;
            n_reg <= 8'h00;
            last_reg <= 12'h000;
        end else begin
            // A start is taken even mid-conversion, as the second section allows
            if (sh_reg && !sample_hold_in && !chip_select_n_in && standby_request_n_in) begin
                conv_active_out <= 1'b0;
                sel_reg <= input_select_in;
                cnt_reg <= conv_cyc_in;
            end else if (!conv_active_out && cnt_reg <= 8'h01) begin
                conv_active_out <= 1'b1;
                lat_reg <= {sel_reg, 3'h5, n_reg};
                n_reg <= n_reg + 8'h01;
                done_irq_n_out <= 1'b0;
            end else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
            if (!chip_select_n_in && !read_n_in) done_irq_n_out <= 1'b1;
        end
    end
endmodule : adc_dev_model
`default_nettype wire

/* sim/adc_host_control_interface_tb.sv */
// Testbench for the converter host controller with a device model
`default_nettype none
module adc_host_control_interface_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_ctrl_pkg::*;
    logic ref_clk_in, reset_in, start_in, channel_in, standby_in, busy_out, result_valid_out, result_channel_out;
    logic cs_n, sh, rd_n, oe, sel, stb_n, conv_act, irq_n;
    logic [RESULT_W-1:0] result_data_out, bus;
    logic [7:0] conv_cyc, n_exp;
    int n_fail, cmp_count;
    adc_host_ctrl adc_host_ctrl_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .start_in(start_in),
        .channel_in(channel_in), .standby_in(standby_in), .busy_out(busy_out),
        .result_valid_out(result_valid_out), .result_data_out(result_data_out),
        .result_channel_out(result_channel_out), .chip_select_n_out(cs_n), .sample_hold_out(sh),
        .read_n_out(rd_n), .output_enable_out(oe), .input_select_out(sel), .standby_request_n_out(stb_n),
        .conv_active_in(conv_act), .done_irq_n_in(irq_n), .result_bus_in(bus));
    adc_dev_model adc_dev_model_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .conv_cyc_in(conv_cyc),
        .chip_select_n_in(cs_n), .sample_hold_in(sh), .read_n_in(rd_n), .output_enable_in(oe),
        .input_select_in(sel), .standby_request_n_in(stb_n), .conv_active_out(conv_act),
        .done_irq_n_out(irq_n), .result_bus_out(bus));
    always #10 ref_clk_in = ~ref_clk_in;
    task automatic wrap_up();
        if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Bounded wait for busy (0) or the result pulse (1)
    task automatic wait_hi(input logic which);
        for (int i = 0; i < 400; i++) begin
            @(posedge ref_clk_in);
            #1;
            if ((which ? result_valid_out : busy_out) === 1'b1) return;
        end
        n_fail++;
        wrap_up();
    endtask : wait_hi
    task automatic t_conv(input logic ch, input logic [7:0] cc);
        conv_cyc = cc;
        channel_in = ch;
        start_in = 1'b1;
        wait_hi(1'b0);
        start_in = 1'b0;
        wait_hi(1'b1);
        chk(result_data_out, {ch, 3'h5, n_exp});
        chk(12'(result_channel_out), 12'(ch));
        n_exp++;
    endtask : t_conv
    task automatic t_standby();
        logic [7:0] bad;
        bad = 8'h00;
        standby_in = 1'b1;
        start_in = 1'b1;
        repeat (40) begin
            @(posedge ref_clk_in);
            #1;
            if (sh !== 1'b1 || busy_out !== 1'b0) bad++;
        end
        chk(12'(bad), 12'h000);
        chk(12'(stb_n), 12'h000);
        standby_in = 1'b0;
        start_in = 1'b0;
        // Let an edge pass so the next start is not a second assignment in this step
        @(posedge ref_clk_in);
        #1;
    endtask : t_standby
    initial begin
        {ref_clk_in, start_in, channel_in, standby_in} = 4'h0;
        reset_in = 1'b1;
        conv_cyc = 8'h06;
        n_exp = 8'h00;
        repeat (5) @(posedge ref_clk_in);
        #1 reset_in = 1'b0;
        chk(12'({cs_n, sh, rd_n, oe, sel, stb_n, busy_out, result_valid_out}), 12'h0e4);
        t_conv(1'b0, 8'h06);
        t_conv(1'b1, 8'h01);
        t_conv(1'b1, 8'h3c);
        t_standby();
        t_conv(1'b0, 8'h03);
        wrap_up();
    end
endmodule : adc_host_control_interface_tb
`default_nettype wire
